// ---- pkg/fqlp_pkg.sv ----
// Constants, field layouts and encodings for the feature query / log page fetch block.
// Assumes a single 125 MHz controller clock; no other package is needed.
package fqlp_pkg;

    // Avalon-MM register word offsets (byte address = 4 * index)
    localparam logic [3:0] REG_CMD_DW10    = 4'h0;
    localparam logic [3:0] REG_PTR1_LO     = 4'h1;
    localparam logic [3:0] REG_PTR1_HI     = 4'h2;
    localparam logic [3:0] REG_PTR2_LO     = 4'h3;
    localparam logic [3:0] REG_PTR2_HI     = 4'h4;
    localparam logic [3:0] REG_CTRL        = 4'h5;
    localparam logic [3:0] REG_STATUS      = 4'h6;
    localparam logic [3:0] REG_CPL_DW0     = 4'h7;
    localparam logic [3:0] REG_XFER_LEN    = 4'h8;
    localparam logic [3:0] REG_FEAT_ADDR   = 4'h9;
    localparam logic [3:0] REG_FEAT_DATA   = 4'ha;
    localparam logic [3:0] REG_CAP_MASK    = 4'hb;

    // Control register bits
    localparam int CTRL_GO_FEAT  = 0;
    localparam int CTRL_GO_LOG   = 1;
    localparam int CTRL_SAVE_EN  = 2;
    localparam int CTRL_RSV_NOTE = 3;

    // Feature table write target bank in REG_FEAT_ADDR bits 9:8
    localparam logic [1:0] BANK_CUR = 2'h0;
    localparam logic [1:0] BANK_DEF = 2'h1;
    localparam logic [1:0] BANK_SAV = 2'h2;

    // Query command word fields
    localparam int SEL_HI = 10;
    localparam int SEL_LO = 8;
    localparam int FID_HI = 7;
    localparam int FID_LO = 0;
    // Log fetch command word fields
    localparam int NUMD_HI = 27;
    localparam int NUMD_LO = 16;
    localparam int LID_HI  = 7;
    localparam int LID_LO  = 0;

    localparam logic [2:0] SEL_CURRENT = 3'h0;
    localparam logic [2:0] SEL_DEFAULT = 3'h1;
    localparam logic [2:0] SEL_SAVED   = 3'h2;
    localparam logic [2:0] SEL_CAPS    = 3'h3;

    localparam int CAP_SAVEABLE = 0;
    localparam int CAP_NS_SPEC  = 1;
    localparam int CAP_CHANGE   = 2;

    localparam logic [7:0] LID_ERROR    = 8'h01;
    localparam logic [7:0] LID_HEALTH   = 8'h02;
    localparam logic [7:0] LID_FW_SLOT  = 8'h03;
    localparam logic [7:0] LID_RSV_NOTE = 8'h80;
    localparam logic [7:0] LID_CS_FIRST = 8'h80;
    localparam logic [7:0] LID_VS_FIRST = 8'hc0;

    // Completion status codes
    localparam logic [7:0] STS_OK      = 8'h00;
    localparam logic [7:0] STS_BAD_LID = 8'h09;
    localparam logic [7:0] STS_BAD_SEL = 8'h02;

    localparam logic [31:0] PAGE_BYTES = 32'h0000_1000;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;

    typedef enum logic [1:0] {
        FQLP_RSV  = 2'h0,
        FQLP_MAND = 2'h1,
        FQLP_CSS  = 2'h2,
        FQLP_VS   = 2'h3
    } fqlp_lid_class_t;

    // Gray-coded states along idle -> lookup -> post -> done
    typedef enum logic [1:0] {
        FQLP_IDLE = 2'b00,
        FQLP_LOOK = 2'b01,
        FQLP_POST = 2'b11,
        FQLP_DONE = 2'b10
    } fqlp_state_t;

endpackage : fqlp_pkg

// ---- rtl/fqlp_feat_mem.sv ----
// Feature attribute store: 256 words, one per feature identifier.
// Assumes one writer and one reader on the same clock; read data is registered.
`timescale 1ns/10ps
module fqlp_feat_mem (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_addr,
    input  wire logic [31:0] wr_data,
    input  wire logic [7:0]  rd_addr,
    output logic      [31:0] rd_data
);
    logic [31:0] mem [0:255];

    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= fqlp_pkg::RST_WORD;
        end else if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : fqlp_feat_mem

// ---- rtl/fqlp_top.sv ----
// Controller-side handling of the feature query and log page fetch admin commands.
// Assumes an Avalon-MM master on clk and a completion sink that takes one-cycle pulses.
// Operation
// - Select 000b returns current value
// - Select 001b returns default value
// - Select 010b returns last saved value
// - Select 011b reports capabilities in completion Dword0
// - Dword0 bit 0 means saveable
// - Dword0 bit 1 means namespace specific
// - Dword0 bit 2 means changeable
// - Post completion only after attributes returned
// - Feature specific info placed in Dword0
// - Log fetch uses pointers and Dword10 only
// - First pointer is buffer start address
// - Second pointer ignored unless crossing page
// - Dword count is zero based
// - Log identifier from Dword10 bits 7:0
// - Pages 01h, 02h, 03h are supported
// - Classify reserved, command set, vendor ranges
// - 80h reservation notification, 81h-BFh reserved
// - Select field bits 10:8; saved falls back
// - Feature identifier from bits 7:0
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module fqlp_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             cpl_valid,
    output logic      [31:0] cpl_dw0,
    output logic      [7:0]  cpl_status,
    output logic             xfer_valid,
    output logic      [63:0] xfer_addr1,
    output logic      [63:0] xfer_addr2,
    output logic             xfer_use2,
    output logic      [13:0] xfer_bytes,
    output logic      [7:0]  xfer_lid
);
    logic [31:0]              cmd_q;
    logic [63:0]              ptr1_q;
    logic [63:0]              ptr2_q;
    logic [3:0]               ctrl_q;
    logic [9:0]               faddr_q;
    logic [31:0]              cap_q [0:7];
    logic [255:0]             sav_valid_q;
    logic                     busy_q;
    logic                     is_log_q;
    fqlp_pkg::fqlp_state_t    st_q;
    logic [31:0]              cpl_dw0_q;
    logic [7:0]               cpl_sts_q;
    logic                     cpl_valid_q;
    logic [31:0]              rdata_q;
    logic                     rack_q;
    logic                     mem_we;
    logic [7:0]               mem_waddr;
    logic [7:0]               mem_raddr;
    logic [31:0]              cur_rd;
    logic [31:0]              def_rd;
    logic [31:0]              sav_rd;
    logic [2:0]               sel_eff;
    logic [7:0]               fid;
    logic [7:0]               lid;
    logic [11:0]              numd;
    logic [2:0]               caps;
    fqlp_pkg::fqlp_lid_class_t lid_cls;
    logic                     lid_ok;
    logic                     bus_wr;
    logic [31:0]              wmask;

    // Byte-lane merge used for every writable register except REG_CTRL, REG_FEAT_ADDR and REG_FEAT_DATA
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic fqlp_pkg::fqlp_lid_class_t lid_class(input logic [7:0] id);
        if (id >= fqlp_pkg::LID_VS_FIRST) begin
            return fqlp_pkg::FQLP_VS;
        end else if (id >= fqlp_pkg::LID_CS_FIRST) begin
            return fqlp_pkg::FQLP_CSS;
        end else if (id == fqlp_pkg::LID_ERROR || id == fqlp_pkg::LID_HEALTH ||
                     id == fqlp_pkg::LID_FW_SLOT) begin
            return fqlp_pkg::FQLP_MAND;
        end else begin
            return fqlp_pkg::FQLP_RSV;
        end
    endfunction : lid_class

    assign bus_wr = ce && avs_write && !busy_q;
    assign wmask  = be_merge(32'h0, 32'hffff_ffff, avs_byteenable);

    // Writes stall while a command runs, reads take one wait cycle; a frozen block stalls all
    assign avs_waitrequest = (avs_write && busy_q) || (avs_read && !rack_q) ||
                             ((avs_read || avs_write) && !ce);

    assign fid  = cmd_q[fqlp_pkg::FID_HI:fqlp_pkg::FID_LO];
    assign lid  = cmd_q[fqlp_pkg::LID_HI:fqlp_pkg::LID_LO];
    assign numd = cmd_q[fqlp_pkg::NUMD_HI:fqlp_pkg::NUMD_LO];
    assign lid_cls = lid_class(lid);

    // Only mandatory pages and, when enabled, 80h are served
    always_comb begin
        case (lid_cls)
            fqlp_pkg::FQLP_MAND: lid_ok = 1'b1;
            fqlp_pkg::FQLP_CSS:  lid_ok = (lid == fqlp_pkg::LID_RSV_NOTE) &&
                                          ctrl_q[fqlp_pkg::CTRL_RSV_NOTE];
            default:             lid_ok = 1'b0;
        endcase
    end

    // Saved request falls back to default when nothing is saved
    always_comb begin
        sel_eff = cmd_q[fqlp_pkg::SEL_HI:fqlp_pkg::SEL_LO];
        if (sel_eff == fqlp_pkg::SEL_SAVED &&
            (!ctrl_q[fqlp_pkg::CTRL_SAVE_EN] || !sav_valid_q[fid])) begin
            sel_eff = fqlp_pkg::SEL_DEFAULT;
        end
    end

    // Capability bits: saveable, namespace specific, changeable
    function automatic logic [2:0] cap_bits(input logic [7:0] f);
        logic [31:0] w;
        w = cap_q[f[2:0]];
        return w[f[7:3]*3 % 24 +: 3];
    endfunction : cap_bits

    assign caps = cap_bits(fid);

    // Register writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q   <= fqlp_pkg::RST_WORD;
            ptr1_q  <= 64'h0;
            ptr2_q  <= 64'h0;
            ctrl_q  <= 4'h0;
            faddr_q <= 10'h0;
        end else if (bus_wr) begin
            case (avs_address)
                fqlp_pkg::REG_CMD_DW10:  cmd_q <= be_merge(cmd_q, avs_writedata, avs_byteenable);
                fqlp_pkg::REG_PTR1_LO:   ptr1_q[31:0]  <= be_merge(ptr1_q[31:0], avs_writedata,
                                                                   avs_byteenable);
                fqlp_pkg::REG_PTR1_HI:   ptr1_q[63:32] <= be_merge(ptr1_q[63:32], avs_writedata,
                                                                   avs_byteenable);
                fqlp_pkg::REG_PTR2_LO:   ptr2_q[31:0]  <= be_merge(ptr2_q[31:0], avs_writedata,
                                                                   avs_byteenable);
                fqlp_pkg::REG_PTR2_HI:   ptr2_q[63:32] <= be_merge(ptr2_q[63:32], avs_writedata,
                                                                   avs_byteenable);
                fqlp_pkg::REG_CTRL:      ctrl_q[3:2] <= avs_writedata[3:2] & wmask[3:2];
                fqlp_pkg::REG_FEAT_ADDR: faddr_q <= avs_writedata[9:0];
                default: begin
                end
            endcase
        end
    end

    // Capability table: 3 bits per feature, 8 features per word slice of 24 bits
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_cap
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cap_q[g] <= fqlp_pkg::RST_WORD;
                end else if (bus_wr && avs_address == fqlp_pkg::REG_CAP_MASK &&
                             faddr_q[2:0] == 3'(g)) begin
                    cap_q[g] <= be_merge(cap_q[g], avs_writedata, avs_byteenable);
                end
            end
        end
    endgenerate

    // Three attribute banks share one memory shape each
    assign mem_we    = bus_wr && avs_address == fqlp_pkg::REG_FEAT_DATA;
    assign mem_waddr = faddr_q[7:0];
    assign mem_raddr = fid;

    fqlp_feat_mem u_cur (
        .clk     (clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .wr_en   (mem_we && faddr_q[9:8] == fqlp_pkg::BANK_CUR),
        .wr_addr (mem_waddr),
        .wr_data (avs_writedata),
        .rd_addr (mem_raddr),
        .rd_data (cur_rd)
    );
    fqlp_feat_mem u_def (
        .clk     (clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .wr_en   (mem_we && faddr_q[9:8] == fqlp_pkg::BANK_DEF),
        .wr_addr (mem_waddr),
        .wr_data (avs_writedata),
        .rd_addr (mem_raddr),
        .rd_data (def_rd)
    );
    fqlp_feat_mem u_sav (
        .clk     (clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .wr_en   (mem_we && faddr_q[9:8] == fqlp_pkg::BANK_SAV),
        .wr_addr (mem_waddr),
        .wr_data (avs_writedata),
        .rd_addr (mem_raddr),
        .rd_data (sav_rd)
    );

    // A write to the saved bank stands for an error-free set with save flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sav_valid_q <= 256'h0;
        end else if (mem_we && faddr_q[9:8] == fqlp_pkg::BANK_SAV) begin
            sav_valid_q[faddr_q[7:0]] <= 1'b1;
        end
    end

    // Command sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q     <= fqlp_pkg::FQLP_IDLE;
            busy_q   <= 1'b0;
            is_log_q <= 1'b0;
        end else if (ce) begin
            case (st_q)
                fqlp_pkg::FQLP_IDLE: begin
                    if (bus_wr && avs_address == fqlp_pkg::REG_CTRL &&
                        (avs_writedata[fqlp_pkg::CTRL_GO_FEAT] ||
                         avs_writedata[fqlp_pkg::CTRL_GO_LOG])) begin
                        st_q     <= fqlp_pkg::FQLP_LOOK;
                        busy_q   <= 1'b1;
                        is_log_q <= avs_writedata[fqlp_pkg::CTRL_GO_LOG];
                    end
                end
                fqlp_pkg::FQLP_LOOK: st_q <= fqlp_pkg::FQLP_POST;
                fqlp_pkg::FQLP_POST: st_q <= fqlp_pkg::FQLP_DONE;
                fqlp_pkg::FQLP_DONE: begin
                    st_q   <= fqlp_pkg::FQLP_IDLE;
                    busy_q <= 1'b0;
                end
                default: st_q <= fqlp_pkg::FQLP_IDLE;
            endcase
        end
    end

    // Result assembly at POST, once memory read data has settled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpl_dw0_q   <= fqlp_pkg::RST_WORD;
            cpl_sts_q   <= fqlp_pkg::STS_OK;
            cpl_valid_q <= 1'b0;
        end else if (ce) begin
            cpl_valid_q <= 1'b0;
            if (st_q == fqlp_pkg::FQLP_POST) begin
                cpl_valid_q <= 1'b1;
                cpl_sts_q   <= fqlp_pkg::STS_OK;
                if (is_log_q) begin
                    cpl_dw0_q <= fqlp_pkg::RST_WORD;
                    if (!lid_ok) begin
                        cpl_sts_q <= fqlp_pkg::STS_BAD_LID;
                    end
                end else begin
                    case (sel_eff)
                        fqlp_pkg::SEL_CURRENT: cpl_dw0_q <= cur_rd;
                        fqlp_pkg::SEL_DEFAULT: cpl_dw0_q <= def_rd;
                        fqlp_pkg::SEL_SAVED:   cpl_dw0_q <= sav_rd;
                        fqlp_pkg::SEL_CAPS:    cpl_dw0_q <= {29'h0, caps};
                        default: begin
                            cpl_dw0_q <= fqlp_pkg::RST_WORD;
                            cpl_sts_q <= fqlp_pkg::STS_BAD_SEL;
                        end
                    endcase
                end
            end
        end
    end

    // Data mover request, issued together with a good log completion
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xfer_valid <= 1'b0;
            xfer_addr1 <= 64'h0;
            xfer_addr2 <= 64'h0;
            xfer_use2  <= 1'b0;
            xfer_bytes <= 14'h0;
            xfer_lid   <= 8'h0;
        end else if (ce) begin
            xfer_valid <= 1'b0;
            if (st_q == fqlp_pkg::FQLP_POST && is_log_q && lid_ok) begin
                xfer_valid <= 1'b1;
                xfer_addr1 <= ptr1_q;
                // A full 4096-dword count wraps to zero in this 14-bit length
                xfer_bytes <= {numd + 12'h1, 2'b00};
                xfer_lid   <= lid;
                // Second pointer is a direct buffer address, never a list
                if ({20'h0, ptr1_q[11:0]} + {18'h0, numd + 12'h1, 2'b00} > fqlp_pkg::PAGE_BYTES)
                begin
                    xfer_use2  <= 1'b1;
                    xfer_addr2 <= ptr2_q;
                end else begin
                    xfer_use2  <= 1'b0;
                    xfer_addr2 <= 64'h0;
                end
            end
        end
    end

    assign cpl_valid  = cpl_valid_q;
    assign cpl_dw0    = cpl_dw0_q;
    assign cpl_status = cpl_sts_q;

    // Read path
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= fqlp_pkg::RST_WORD;
            rack_q  <= 1'b0;
        end else if (ce) begin
            rack_q <= avs_read && !rack_q;
            case (avs_address)
                fqlp_pkg::REG_CMD_DW10:  rdata_q <= cmd_q;
                fqlp_pkg::REG_PTR1_LO:   rdata_q <= ptr1_q[31:0];
                fqlp_pkg::REG_PTR1_HI:   rdata_q <= ptr1_q[63:32];
                fqlp_pkg::REG_PTR2_LO:   rdata_q <= ptr2_q[31:0];
                fqlp_pkg::REG_PTR2_HI:   rdata_q <= ptr2_q[63:32];
                fqlp_pkg::REG_CTRL:      rdata_q <= {28'h0, ctrl_q[3:2], 2'b00};
                fqlp_pkg::REG_STATUS:    rdata_q <= {20'h0, cpl_sts_q, st_q, busy_q, 1'b0};
                fqlp_pkg::REG_CPL_DW0:   rdata_q <= cpl_dw0_q;
                fqlp_pkg::REG_XFER_LEN:  rdata_q <= {18'h0, xfer_bytes};
                fqlp_pkg::REG_FEAT_ADDR: rdata_q <= {22'h0, faddr_q};
                fqlp_pkg::REG_CAP_MASK:  rdata_q <= cap_q[faddr_q[2:0]];
                default:                 rdata_q <= fqlp_pkg::RST_WORD;
            endcase
        end
    end
    assign avs_readdata = rdata_q;

    property p_cpl_after_look;
        @(posedge clk) disable iff (!rst_b)
        (ce && st_q == fqlp_pkg::FQLP_LOOK) ##1 ce |-> ##1 cpl_valid;
    endproperty
    a_cpl_after_look: assert property (p_cpl_after_look) else $error("completion late");

    property p_caps_dw0;
        @(posedge clk) disable iff (!rst_b)
        (ce && st_q == fqlp_pkg::FQLP_POST && !is_log_q && sel_eff == fqlp_pkg::SEL_CAPS)
        |=> cpl_dw0[31:3] == 29'h0;
    endproperty
    a_caps_dw0: assert property (p_caps_dw0) else $error("caps dword bad");

    property p_cur_sel;
        @(posedge clk) disable iff (!rst_b)
        (ce && st_q == fqlp_pkg::FQLP_POST && !is_log_q && sel_eff == fqlp_pkg::SEL_CURRENT)
        |=> cpl_dw0 == $past(cur_rd);
    endproperty
    a_cur_sel: assert property (p_cur_sel) else $error("current value bad");

    property p_def_sel;
        @(posedge clk) disable iff (!rst_b)
        (ce && st_q == fqlp_pkg::FQLP_POST && !is_log_q && sel_eff == fqlp_pkg::SEL_DEFAULT)
        |=> cpl_dw0 == $past(def_rd);
    endproperty
    a_def_sel: assert property (p_def_sel) else $error("default value bad");

    property p_fallback;
        @(posedge clk) disable iff (!rst_b)
        (cmd_q[10:8] == fqlp_pkg::SEL_SAVED && !sav_valid_q[fid])
        |-> sel_eff == fqlp_pkg::SEL_DEFAULT;
    endproperty
    a_fallback: assert property (p_fallback) else $error("saved fallback bad");

    property p_bad_lid;
        @(posedge clk) disable iff (!rst_b)
        (ce && st_q == fqlp_pkg::FQLP_POST && is_log_q && lid_cls == fqlp_pkg::FQLP_RSV)
        |=> cpl_valid && cpl_status == fqlp_pkg::STS_BAD_LID && !xfer_valid;
    endproperty
    a_bad_lid: assert property (p_bad_lid) else $error("reserved id accepted");

    property p_len;
        @(posedge clk) disable iff (!rst_b)
        xfer_valid |-> xfer_bytes == {$past(numd) + 12'h1, 2'b00};
    endproperty
    a_len: assert property (p_len) else $error("length bad");

    property p_addr1;
        @(posedge clk) disable iff (!rst_b)
        xfer_valid |-> xfer_addr1 == $past(ptr1_q) && xfer_lid == $past(lid);
    endproperty
    a_addr1: assert property (p_addr1) else $error("start address bad");

    property p_mand;
        @(posedge clk) disable iff (!rst_b)
        (lid == fqlp_pkg::LID_ERROR || lid == fqlp_pkg::LID_HEALTH ||
         lid == fqlp_pkg::LID_FW_SLOT) |-> lid_ok;
    endproperty
    a_mand: assert property (p_mand) else $error("mandatory page refused");
endmodule : fqlp_top

// ---- verif/fqlp_cq_model.sv ----
// Completion queue and data mover stand-in: counts and records each completion and transfer.
// Assumes one-cycle pulses on clk, with the data valid in the pulse cycle.
`timescale 1ns/10ps
module fqlp_cq_model (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         cpl_valid,
    input  wire logic [39:0]  cpl_info,
    input  wire logic         xfer_valid,
    input  wire logic [150:0] xfer_info,
    output logic      [7:0]   n_cpl,
    output logic      [7:0]   n_xfer,
    output logic      [39:0]  cpl_q,
    output logic      [150:0] xfer_q
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            n_cpl <= 8'h00;
            cpl_q <= 40'h00_0000_0000;
        end else if (cpl_valid) begin
            n_cpl <= n_cpl + 8'h01;
            cpl_q <= cpl_info;
        end
    end

    // Only the pulse cycle counts; the data lines are not trusted afterwards
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            n_xfer <= 8'h00;
            xfer_q <= '0;
        end else if (xfer_valid) begin
            n_xfer <= n_xfer + 8'h01;
            xfer_q <= xfer_info;
        end
    end
endmodule : fqlp_cq_model

// ---- verif/tb_fqlp_top.sv ----
// Self-checking bench: register bus tasks drive feature queries and log fetches.
// Assumes the completion model records every pulse the block emits.
`timescale 1ns/10ps
module tb_fqlp_top;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    logic         ce = 1'b1;
    logic [3:0]   avs_address = 4'h0;
    logic         avs_read = 1'b0;
    logic         avs_write = 1'b0;
    logic [31:0]  avs_writedata = 32'h0;
    logic [31:0]  avs_readdata, rdat, dw0;
    logic         avs_waitrequest, cpl_valid, xfer_valid, xfer_use2;
    logic [31:0]  cpl_dw0;
    logic [7:0]   cpl_status, xfer_lid, n_cpl, n_xfer, sts, x0;
    logic [63:0]  xfer_addr1, xfer_addr2;
    logic [13:0]  xfer_bytes;
    logic [39:0]  cpl_q;
    logic [150:0] xfer_q;
    int           fail_count = 0;
    int           total_checks = 0;

    always #4 clk = ~clk;

    fqlp_top u_fqlp_top (.clk, .rst_b, .ce, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .cpl_valid,
        .cpl_dw0, .cpl_status, .xfer_valid, .xfer_addr1, .xfer_addr2, .xfer_use2, .xfer_bytes,
        .xfer_lid);
    fqlp_cq_model u_fqlp_cq_model (.clk, .rst_b, .cpl_valid, .cpl_info({cpl_status, cpl_dw0}),
        .xfer_valid, .xfer_info({xfer_use2, xfer_bytes, xfer_lid, xfer_addr1, xfer_addr2}),
        .n_cpl, .n_xfer, .cpl_q, .xfer_q);

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    function automatic void chk(input string n, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endfunction : chk

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
        avs_read <= r;
        avs_write <= !r;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Idle edge so the next call never drives a strobe twice in one step
        @(posedge clk);
    endtask : bus

    task automatic cmd(input logic [31:0] d10, input logic [31:0] ctl);
        logic [7:0] c0;
        int k;
        bus(1'b0, fqlp_pkg::REG_CMD_DW10, d10);
        c0 = n_cpl;
        x0 = n_xfer;
        bus(1'b0, fqlp_pkg::REG_CTRL, ctl);
        k = 0;
        while (n_cpl === c0 && k < 20) begin
            @(posedge clk);
            k++;
        end
        chk("completions", {56'h0, c0 + 8'h01}, {56'h0, n_cpl});
        {sts, dw0} = cpl_q;
    endtask : cmd

    task automatic q(input logic [2:0] s, input logic [7:0] f, input logic [31:0] ctl,
                     input logic [31:0] e, input logic [7:0] es);
        cmd({21'h0, s, f}, ctl);
        chk("cpl_dw0", {32'h0, e}, {32'h0, dw0});
        chk("cpl_status", {56'h0, es}, {56'h0, sts});
    endtask : q

    task automatic setf(input logic [1:0] b, input logic [7:0] f, input logic [31:0] v);
        bus(1'b0, fqlp_pkg::REG_FEAT_ADDR, {22'h0, b, f});
        bus(1'b0, fqlp_pkg::REG_FEAT_DATA, v);
    endtask : setf

    // Reserved dword 10 bits are driven to ones on every fetch
    task automatic lg(input logic [7:0] lid, input logic [11:0] nd, input logic [31:0] ctl,
                      input logic ok, input logic u2);
        cmd({4'hf, nd, 8'hff, lid}, ctl);
        chk("status", {56'h0, ok ? fqlp_pkg::STS_OK : fqlp_pkg::STS_BAD_LID}, {56'h0, sts});
        chk("xfers", {56'h0, x0 + {7'h0, ok}}, {56'h0, n_xfer});
        if (ok) begin
            chk("lid", {56'h0, lid}, {56'h0, xfer_q[135:128]});
            chk("bytes", (64'(nd) + 64'h1) * 64'h4, {50'h0, xfer_q[149:136]});
            chk("addr1", u2 ? 64'h1_0000_1ff0 : 64'h1_0000_1000, xfer_q[127:64]);
            chk("use2", {63'h0, u2}, {63'h0, xfer_q[150]});
            if (u2) chk("addr2", 64'h2_0000_5000, xfer_q[63:0]);
        end
    endtask : lg

    initial begin
        #100000;
        fail_count++;
        summarize();
    end

    initial begin
        logic [7:0] bad [7] = '{8'h00, 8'h04, 8'h7f, 8'h81, 8'hbf, 8'hc0, 8'hff};
        logic [7:0] good [4] = '{8'h01, 8'h02, 8'h03, 8'h80};
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        setf(fqlp_pkg::BANK_CUR, 8'h05, 32'h1111_aaaa);
        setf(fqlp_pkg::BANK_DEF, 8'h05, 32'h2222_bbbb);
        setf(fqlp_pkg::BANK_SAV, 8'h05, 32'h3333_cccc);
        setf(fqlp_pkg::BANK_DEF, 8'h06, 32'h4444_dddd);
        q(3'h0, 8'h05, 32'hd, 32'h1111_aaaa, fqlp_pkg::STS_OK);
        q(3'h1, 8'h05, 32'hd, 32'h2222_bbbb, fqlp_pkg::STS_OK);
        q(3'h2, 8'h05, 32'hd, 32'h3333_cccc, fqlp_pkg::STS_OK);
        q(3'h2, 8'h06, 32'hd, 32'h4444_dddd, fqlp_pkg::STS_OK);
        q(3'h2, 8'h05, 32'h9, 32'h2222_bbbb, fqlp_pkg::STS_OK);
        bus(1'b1, fqlp_pkg::REG_CPL_DW0, 32'h0);
        chk("reg_cpl_dw0", 64'h2222_bbbb, {32'h0, rdat});
        q(3'h4, 8'h05, 32'hd, 32'h0, fqlp_pkg::STS_BAD_SEL);
        bus(1'b0, 4'hf, 32'hdead_beef);
        bus(1'b1, 4'hf, 32'h0);
        chk("unmapped", 64'h0, {32'h0, rdat});
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, fqlp_pkg::REG_FEAT_ADDR, 32'h5);
            bus(1'b0, fqlp_pkg::REG_CAP_MASK, 32'h1 << i);
            q(3'h3, 8'h05, 32'hd, 32'h1 << i, fqlp_pkg::STS_OK);
        end
        bus(1'b0, fqlp_pkg::REG_PTR1_LO, 32'h0000_1000);
        bus(1'b0, fqlp_pkg::REG_PTR1_HI, 32'h1);
        bus(1'b0, fqlp_pkg::REG_PTR2_LO, 32'h0000_5000);
        bus(1'b0, fqlp_pkg::REG_PTR2_HI, 32'h2);
        foreach (good[i]) lg(good[i], 12'h00f, 32'he, 1'b1, 1'b0);
        foreach (bad[i]) lg(bad[i], 12'h00f, 32'he, 1'b0, 1'b0);
        lg(8'h80, 12'h00f, 32'h6, 1'b0, 1'b0);
        bus(1'b0, fqlp_pkg::REG_PTR1_LO, 32'h0000_1ff0);
        lg(8'h02, 12'h007, 32'he, 1'b1, 1'b1);
        summarize();
    end
endmodule : tb_fqlp_top
